// file: src/pmc_mode_button_control.sv
// Summary of operation
// - Source select: 00 greater, 01 battery, 10 input, 11 disconnect both.
// - Reset returns source select to greater-of-battery-or-input.
// - Analog supply below prewarn threshold raises an event.
// - Button deglitched 200 us; filtered fall in standby starts power-up.
// - Filtered fall ignored during power-up or power-down sequence.
// - Button low past long-press duration resets device and rails.
// - Per-mode revert bit decides whether button fall returns to mode 0.
// - Filtered button fall clears pin-mode-select enable at 22h.
// - Button level readable at bit 7 of register 0x71.
// - Temperature charge control only while thermistor monitor enabled.
// - Temperature classed by cold, cool, warm, hot comparators.
// - Hot or cold suspends charging and pauses safety timer.
// - Cold-cool halves charge current; cool-warm charges normally.
// - Warm-hot lowers charge voltage target by about 140 mV.
// - Four mode setting registers; start in mode 0.
// - Pin-select enable 0: host mode bits steer mode, pins ignored.
// - Pin-select enable 1: mode pins steer mode, host bits ignored.
// - Rails kept enabled change voltage at once on mode switch.
// - New rails enabled and at 90 % before old rails disabled.
// - Clamped: charger stops at rail equal battery, restarts 100 mV above.
// - Clamped stop-restart repeats every 300 ms.
// - Rail below battery enables battery supplement until load below limit.
// - Pins decode with mode pin 1 as upper bit.
//
// Our own choices: the placing of the registers and the plain strobed port.
module pmc_mode_button_control #(
    parameter int MS_CYCLES = pmc_pkg::MS_CYCLES_DEF
) (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic [7:0]                  regRdata,
    input  wire logic                   buttonN,
    input  wire logic                   mode_pin_0,
    input  wire logic                   mode_pin_1,
    input  wire logic                   sequenceDone,
    input  wire logic [3:0]             railGood,
    input  wire logic                   supplyBelowPrewarn,
    input  wire pmc_pkg::pmc_temp_type  tempCmp,
    input  wire logic                   input_current_limit,
    input  wire logic                   railAtBattery,
    input  wire logic                   railAboveBattery,
    input  wire logic                   railBelowBattery,
    output logic [1:0]                  supply_source_select,
    output logic [1:0]                  supply_prewarn_threshold,
    output logic                        prewarnEvent,
    output logic                        powerUpStart,
    output logic                        chipReset,
    output logic [1:0]                  activeMode,
    output logic [3:0]                  railEnable,
    output logic                        voltageUpdate,
    output pmc_pkg::pmc_charge_type     chargeCtrl,
    output logic                        batterySupplement
);

    // Register state.
    logic [7:0] supplyReg, next_supplyReg;
    logic [7:0] chargeReg, next_chargeReg;
    logic [7:0] modeCfg, next_modeCfg;
    logic [7:0] modeReg [4];
    logic [7:0] next_modeReg [4];
    logic       prewarnFlag, next_prewarnFlag;

    // Button filter state.
    logic        btnLast, next_btnLast;
    logic        btnStable, next_btnStable;
    logic [15:0] dgCount, next_dgCount;
    logic        btnFall;

    // Long-press timing.
    logic [16:0] msPre, next_msPre;
    logic [13:0] pressMs, next_pressMs;
    logic [13:0] longLimit;

    // Sequencer.
    pmc_pkg::pmc_seq_type seqState, next_seqState;
    logic [1:0] curMode, next_curMode;
    logic [1:0] tgtMode, next_tgtMode;
    logic [3:0] railEn, next_railEn;
    logic       voltUpd, next_voltUpd;
    logic       upStart, next_upStart;
    logic       doReset, next_doReset;
    logic [1:0] requestMode;
    logic       pinSelect;

    // Charger clamping.
    logic        chgStopped, next_chgStopped;
    logic [8:0]  restartMs, next_restartMs;
    logic        supplement, next_supplement;
    pmc_pkg::pmc_charge_type next_chargeCtrl;
    logic [7:0]  next_regRdata;

    assign btnFall   = (dgCount == 16'(pmc_pkg::DEGLITCH_CYCLES - 1)) && !btnStable && btnLast;
    // The code plus one is kept three bits wide so that code 11 does not wrap to a zero limit.
    assign longLimit = 14'(pmc_pkg::LONG_UNIT_MS) * {11'h000, {1'b0, chargeReg[7:6]} + 3'h1};
    assign pinSelect = modeCfg[curMode];
    // Pin 1 is the upper bit of the pin-selected mode.
    assign requestMode = pinSelect ? {mode_pin_1, mode_pin_0} : modeCfg[5:4];

    always_comb begin
        next_supplyReg   = supplyReg;
        next_chargeReg   = chargeReg;
        next_modeCfg     = modeCfg;
        for (int i = 0; i < 4; i++) begin
            next_modeReg[i] = modeReg[i];
        end
        next_prewarnFlag = prewarnFlag || supplyBelowPrewarn;
        next_regRdata    = 8'h00;
        if (regWrite) begin
            case (regAddr)
                pmc_pkg::OFS_SUPPLY:  next_supplyReg = regWdata;
                pmc_pkg::OFS_CHARGE:  next_chargeReg = regWdata;
                pmc_pkg::OFS_MODECFG: next_modeCfg   = regWdata;
                pmc_pkg::OFS_MODE0:   next_modeReg[0] = regWdata;
                pmc_pkg::OFS_MODE1:   next_modeReg[1] = regWdata;
                pmc_pkg::OFS_MODE2:   next_modeReg[2] = regWdata;
                pmc_pkg::OFS_MODE3:   next_modeReg[3] = regWdata;
                // Writing a one clears the flag, but a new event in the same cycle wins.
                pmc_pkg::OFS_STATUS:  next_prewarnFlag = (prewarnFlag && !regWdata[0]) || supplyBelowPrewarn;
                default: begin
                end
            endcase
        end
        if (btnFall) begin
            next_modeCfg[3:0] = 4'h0;
        end
        if (regRead) begin
            case (regAddr)
                pmc_pkg::OFS_SUPPLY:  next_regRdata = supplyReg;
                pmc_pkg::OFS_CHARGE:  next_regRdata = chargeReg;
                pmc_pkg::OFS_MODECFG: next_regRdata = modeCfg;
                pmc_pkg::OFS_MODE0:   next_regRdata = modeReg[0];
                pmc_pkg::OFS_MODE1:   next_regRdata = modeReg[1];
                pmc_pkg::OFS_MODE2:   next_regRdata = modeReg[2];
                pmc_pkg::OFS_MODE3:   next_regRdata = modeReg[3];
                pmc_pkg::OFS_STATUS:  next_regRdata = {1'b0, seqState, curMode, chgStopped, prewarnFlag};
                pmc_pkg::OFS_RSTMON:  next_regRdata = {btnStable, 7'h00};
                default:              next_regRdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        next_btnLast   = btnStable;
        next_btnStable = btnStable;
        next_dgCount   = dgCount;
        // Any change of the raw level restarts the count, so short glitches never pass.
        if (buttonN != btnStable) begin
            next_btnStable = buttonN;
            next_dgCount   = 16'h0000;
            next_btnLast   = btnLast;
        end else if (dgCount < 16'(pmc_pkg::DEGLITCH_CYCLES - 1)) begin
            next_dgCount = dgCount + 16'h0001;
            next_btnLast = btnLast;
        end
        next_msPre  = (msPre == 17'(MS_CYCLES - 1)) ? 17'h00000 : msPre + 17'h00001;
        next_pressMs = pressMs;
        next_doReset = 1'b0;
        if (btnStable || buttonN) begin
            next_pressMs = 14'h0000;
        end else if (msPre == 17'(MS_CYCLES - 1)) begin
            if (pressMs >= longLimit) begin
                next_doReset = 1'b1;
                next_pressMs = 14'h0000;
            end else begin
                next_pressMs = pressMs + 14'h0001;
            end
        end
    end

    always_comb begin
        next_seqState = seqState;
        next_curMode  = curMode;
        next_tgtMode  = tgtMode;
        next_railEn   = railEn;
        next_voltUpd  = 1'b0;
        next_upStart  = 1'b0;
        case (seqState)
            pmc_pkg::SEQ_STANDBY: begin
                if (btnFall) begin
                    next_upStart  = 1'b1;
                    next_seqState = pmc_pkg::SEQ_POWERUP;
                    next_railEn   = modeReg[0][3:0];
                    next_curMode  = 2'h0;
                end
            end
            pmc_pkg::SEQ_POWERUP: begin
                // Button edges during power-up are dropped here.
                if (sequenceDone) begin
                    next_seqState = pmc_pkg::SEQ_ACTIVE;
                end
            end
            pmc_pkg::SEQ_ACTIVE: begin
                if (btnFall && modeReg[curMode][pmc_pkg::MODE_REVERT_BIT] && curMode != 2'h0) begin
                    next_tgtMode = 2'h0;
                end else begin
                    next_tgtMode = requestMode;
                end
                if (next_tgtMode != curMode) begin
                    next_voltUpd  = 1'b1;
                    next_railEn   = railEn | modeReg[next_tgtMode][3:0];
                    next_seqState = pmc_pkg::SEQ_RAISE;
                end
            end
            pmc_pkg::SEQ_RAISE: begin
                if ((railGood & railEn) == railEn) begin
                    next_railEn   = modeReg[tgtMode][3:0];
                    next_seqState = pmc_pkg::SEQ_LOWER;
                end
            end
            pmc_pkg::SEQ_LOWER: begin
                next_curMode  = tgtMode;
                next_seqState = pmc_pkg::SEQ_ACTIVE;
            end
            default: next_seqState = pmc_pkg::SEQ_STANDBY;
        endcase
    end

    always_comb begin
        next_chgStopped = chgStopped;
        next_restartMs  = restartMs;
        next_supplement = supplement;
        if (input_current_limit && railAtBattery && !chgStopped) begin
            next_chgStopped = 1'b1;
            next_restartMs  = 9'h000;
        end else if (chgStopped) begin
            if (msPre == 17'(MS_CYCLES - 1) && restartMs < 9'(pmc_pkg::RESTART_MS - 1)) begin
                next_restartMs = restartMs + 9'h001;
            end
            if (railAboveBattery && restartMs >= 9'(pmc_pkg::RESTART_MS - 1)) begin
                next_chgStopped = 1'b0;
            end
        end
        if (input_current_limit && railBelowBattery) begin
            next_supplement = 1'b1;
        end else if (!input_current_limit) begin
            next_supplement = 1'b0;
        end
        next_chargeCtrl.chargeEnable = !next_chgStopped;
        next_chargeCtrl.halfCurrent  = 1'b0;
        next_chargeCtrl.timerPause   = 1'b0;
        next_chargeCtrl.cvTarget     = chargeReg[5:0];
        if (supplyReg[2]) begin
            if (tempCmp.hot || tempCmp.cold) begin
                next_chargeCtrl.chargeEnable = 1'b0;
                next_chargeCtrl.timerPause   = 1'b1;
            end else if (tempCmp.cool) begin
                next_chargeCtrl.halfCurrent = 1'b1;
            end else if (tempCmp.warm) begin
                next_chargeCtrl.cvTarget = (chargeReg[5:0] > pmc_pkg::WARM_CV_DROP) ?
                    chargeReg[5:0] - pmc_pkg::WARM_CV_DROP : 6'h00;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || doReset) begin
            supplyReg   <= pmc_pkg::SUPPLY_RST;
            chargeReg   <= pmc_pkg::CHARGE_RST;
            modeCfg     <= pmc_pkg::MODECFG_RST;
            for (int i = 0; i < 4; i++) begin
                modeReg[i] <= pmc_pkg::MODE_RST;
            end
            prewarnFlag <= 1'b0;
            seqState    <= pmc_pkg::SEQ_STANDBY;
            curMode     <= 2'h0;
            tgtMode     <= 2'h0;
            railEn      <= 4'h0;
            voltUpd     <= 1'b0;
            upStart     <= 1'b0;
            chgStopped  <= 1'b0;
            restartMs   <= 9'h000;
            supplement  <= 1'b0;
            chargeCtrl  <= '0;
        end else begin
            supplyReg   <= next_supplyReg;
            chargeReg   <= next_chargeReg;
            modeCfg     <= next_modeCfg;
            for (int i = 0; i < 4; i++) begin
                modeReg[i] <= next_modeReg[i];
            end
            prewarnFlag <= next_prewarnFlag;
            seqState    <= next_seqState;
            curMode     <= next_curMode;
            tgtMode     <= next_tgtMode;
            railEn      <= next_railEn;
            voltUpd     <= next_voltUpd;
            upStart     <= next_upStart;
            chgStopped  <= next_chgStopped;
            restartMs   <= next_restartMs;
            supplement  <= next_supplement;
            chargeCtrl  <= next_chargeCtrl;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            btnLast   <= 1'b1;
            btnStable <= 1'b1;
            dgCount   <= 16'h0000;
            msPre     <= 17'h00000;
            pressMs   <= 14'h0000;
            doReset   <= 1'b0;
            regRdata  <= 8'h00;
            chipReset <= 1'b0;
        end else begin
            btnLast   <= next_btnLast;
            btnStable <= next_btnStable;
            dgCount   <= next_dgCount;
            msPre     <= next_msPre;
            pressMs   <= next_pressMs;
            doReset   <= next_doReset;
            regRdata  <= next_regRdata;
            chipReset <= next_doReset;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            supply_source_select     <= pmc_pkg::SRC_GREATER;
            supply_prewarn_threshold <= 2'h0;
            prewarnEvent             <= 1'b0;
            powerUpStart             <= 1'b0;
            activeMode               <= 2'h0;
            railEnable               <= 4'h0;
            voltageUpdate            <= 1'b0;
            batterySupplement        <= 1'b0;
        end else begin
            supply_source_select     <= supplyReg[1:0];
            supply_prewarn_threshold <= supplyReg[5:4];
            prewarnEvent             <= prewarnFlag;
            powerUpStart             <= upStart;
            activeMode               <= curMode;
            railEnable               <= railEn;
            voltageUpdate            <= voltUpd;
            batterySupplement        <= supplement;
        end
    end

endmodule

// file: src/pmc_pkg.sv
package pmc_pkg;

    localparam int CLK_MHZ = 125;

    // Button deglitch time in microseconds and its cycle count.
    localparam int DEGLITCH_US     = 200;
    localparam int DEGLITCH_CYCLES = DEGLITCH_US * CLK_MHZ;

    // Long-press base unit of 4 s, counted in milliseconds by a prescaler.
    localparam int MS_CYCLES_DEF   = 125000;
    localparam int LONG_UNIT_MS    = 4000;

    // Charger restart period under current clamping.
    localparam int RESTART_MS      = 300;

    // Register offsets.
    localparam logic [7:0] OFS_SUPPLY  = 8'h20;
    localparam logic [7:0] OFS_CHARGE  = 8'h21;
    localparam logic [7:0] OFS_MODECFG = 8'h22;
    localparam logic [7:0] OFS_MODE0   = 8'h23;
    localparam logic [7:0] OFS_MODE1   = 8'h24;
    localparam logic [7:0] OFS_MODE2   = 8'h25;
    localparam logic [7:0] OFS_MODE3   = 8'h26;
    localparam logic [7:0] OFS_STATUS  = 8'h70;
    localparam logic [7:0] OFS_RSTMON  = 8'h71;

    // Source select codes and register reset values.
    localparam logic [1:0] SRC_GREATER = 2'h0;
    localparam logic [1:0] SRC_BATTERY = 2'h1;
    localparam logic [1:0] SRC_INPUT   = 2'h2;
    localparam logic [1:0] SRC_NONE    = 2'h3;
    localparam logic [7:0] SUPPLY_RST  = 8'h00;
    localparam logic [7:0] CHARGE_RST  = 8'h00;
    localparam logic [7:0] MODECFG_RST = 8'h00;
    localparam logic [7:0] MODE_RST    = 8'h00;

    // Mode register field positions: [3:0] rail enables, [4] button revert.
    localparam int MODE_REVERT_BIT = 4;

    // Charge voltage drop in the warm zone, in 20 mV steps of the target code.
    localparam logic [5:0] WARM_CV_DROP = 6'h07;

    typedef enum logic [2:0] {
        SEQ_STANDBY = 3'b000,
        SEQ_POWERUP = 3'b001,
        SEQ_ACTIVE  = 3'b010,
        SEQ_RAISE   = 3'b011,
        SEQ_LOWER   = 3'b100
    } pmc_seq_type;

    typedef struct packed {
        logic       cold;
        logic       cool;
        logic       warm;
        logic       hot;
    } pmc_temp_type;

    typedef struct packed {
        logic       chargeEnable;
        logic       halfCurrent;
        logic       timerPause;
        logic [5:0] cvTarget;
    } pmc_charge_type;

endpackage

// file: tb/pmc_host_model.sv
module pmc_host_model #(
    parameter int RAMP = 12
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        powerUpStart,
    input wire logic        chipReset,
    input wire logic [3:0]  railEnable,
    input wire logic [1:0]  pinReq,
    output logic            sequenceDone,
    output logic [3:0]      railGood,
    output logic            mode_pin_0,
    output logic            mode_pin_1
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PIN_HOLD = 625;
    logic [3:0] ramp [RAMP];
    int         holdCnt;
    int         seqCnt;

    initial begin
        {sequenceDone, railGood, mode_pin_0, mode_pin_1} = '0;
        holdCnt = PIN_HOLD;
        seqCnt = 0;
    end

    // Rails report good only after a ramp delay, so the block must really wait for them.
    always @(posedge mclk) begin
        ramp[0] <= railEnable;
        for (int i = 1; i < RAMP; i++) ramp[i] <= ramp[i - 1];
        railGood <= ramp[RAMP - 1] & railEnable;
        if (srst || chipReset) begin
            seqCnt <= 0;
            sequenceDone <= 1'h0;
        end else if (powerUpStart) begin
            seqCnt <= 1;
        end else if (seqCnt > 0 && seqCnt < 40) begin
            seqCnt <= seqCnt + 1;
        end else if (seqCnt == 40) begin
            sequenceDone <= 1'h1;
        end
        holdCnt <= holdCnt < PIN_HOLD ? holdCnt + 1 : holdCnt;
        if (holdCnt >= PIN_HOLD && pinReq != {mode_pin_1, mode_pin_0}) begin
            {mode_pin_1, mode_pin_0} <= pinReq;
            holdCnt <= 0;
        end
    end
endmodule

// file: tb/pmc_mode_button_control_assertions.sv
module pmc_mbc_checker #(
    parameter int MS_CYCLES = pmc_pkg::MS_CYCLES_DEF
) (
    input wire logic                    mclk,
    input wire logic                    srst,
    input wire logic [7:0]              regAddr,
    input wire logic [7:0]              regWdata,
    input wire logic                    regWrite,
    input wire logic                    buttonN,
    input wire logic [3:0]              railGood,
    input wire logic                    supplyBelowPrewarn,
    input wire logic                    input_current_limit,
    input wire logic                    railAtBattery,
    input wire logic                    railBelowBattery,
    input wire logic [1:0]              supply_source_select,
    input wire logic [1:0]              supply_prewarn_threshold,
    input wire logic                    prewarnEvent,
    input wire logic                    powerUpStart,
    input wire logic                    chipReset,
    input wire logic [3:0]              railEnable,
    input wire pmc_pkg::pmc_charge_type chargeCtrl,
    input wire logic                    batterySupplement
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned lowCnt;
    logic [3:0]  pendRails;
    logic        lastReset;

    // The raw low time is counted here because the filter state is hidden inside the block.
    always_ff @(posedge mclk) begin
        lowCnt <= buttonN ? 32'h0 : lowCnt + 32'h1;
        pendRails <= railEnable & ~railGood;
        lastReset <= chipReset;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence s_clamped_at_battery;
        input_current_limit && railAtBattery;
    endsequence
    sequence s_supply_write(d);
        regWrite && regAddr == pmc_pkg::OFS_SUPPLY && d == regWdata;
    endsequence

    property p_supply_fields;
        logic [7:0] d;
        (regWrite && regAddr == pmc_pkg::OFS_SUPPLY, d = regWdata) |-> ##2
            {supply_prewarn_threshold, supply_source_select} == {d[5:4], d[1:0]};
    endproperty
    a_supply_fields: assert property (p_supply_fields) else $error("supply fields not updated");
    property p_reset_source;
        chipReset |-> ##[1:3] supply_source_select == pmc_pkg::SRC_GREATER;
    endproperty
    a_reset_source: assert property (p_reset_source) else $error("source select kept over reset");
    property p_prewarn;
        supplyBelowPrewarn |-> ##[1:3] prewarnEvent;
    endproperty
    a_prewarn: assert property (p_prewarn) else $error("prewarn event missing");
    property p_deglitch;
        powerUpStart |-> lowCnt >= pmc_pkg::DEGLITCH_CYCLES && lowCnt <= pmc_pkg::DEGLITCH_CYCLES + 6;
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("power-up start at wrong low time");
    property p_long_press;
        chipReset |-> lowCnt >= pmc_pkg::LONG_UNIT_MS * MS_CYCLES;
    endproperty
    a_long_press: assert property (p_long_press) else $error("reset before long press");
    property p_rail_order;
        disable iff (srst || chipReset || lastReset)
        ($past(railEnable) & ~railEnable) != 4'h0 |-> (pendRails & railEnable) == 4'h0;
    endproperty
    a_rail_order: assert property (p_rail_order) else $error("rail off before new rails good");
    property p_supplement;
        input_current_limit && railBelowBattery |-> ##[1:3] batterySupplement;
    endproperty
    a_supplement: assert property (p_supplement) else $error("battery supplement missing");
    property p_clamp_stop;
        s_clamped_at_battery |-> ##[1:3] !chargeCtrl.chargeEnable;
    endproperty
    a_clamp_stop: assert property (p_clamp_stop) else $error("charger kept running");
endmodule

bind pmc_mode_button_control pmc_mbc_checker #(.MS_CYCLES(MS_CYCLES)) u_checker (.*);

// file: tb/test_pmic_mode_button_control.sv
module test_pmic_mode_button_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 7;
    localparam int DEG = pmc_pkg::DEGLITCH_CYCLES;
    localparam logic [3:0] ZONES [5] = '{4'hC, 4'h4, 4'h0, 4'h2, 4'h3};
    localparam logic [3:0] RAILS [4] = '{4'h3, 4'h6, 4'hC, 4'h9};
    logic                    mclk, srst, regWrite, regRead, buttonN, mode_pin_0, mode_pin_1;
    logic                    sequenceDone, supplyBelowPrewarn, input_current_limit, railAtBattery;
    logic                    railAboveBattery, railBelowBattery, prewarnEvent, powerUpStart;
    logic                    chipReset, voltageUpdate, batterySupplement;
    logic [7:0]              regAddr, regWdata, regRdata, rv, d;
    logic [3:0]              railGood, railEnable;
    logic [1:0]              supply_source_select, supply_prewarn_threshold, activeMode, pinReq;
    logic [5:0]              cv;
    logic [8:0]              m;
    pmc_pkg::pmc_temp_type   tempCmp;
    pmc_pkg::pmc_charge_type chargeCtrl;
    int                      n_mismatch, compares, t, pu, cr, vu;

    pmc_mode_button_control #(.MS_CYCLES(MSC)) dut (.*);
    pmc_host_model u_host (.*);

    always #4 mclk = ~mclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk);
            t++;
            if (powerUpStart === 1'h1) pu = t;
            if (chipReset === 1'h1) cr = t;
            if (voltageUpdate === 1'h1) vu++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= v;
        @(posedge mclk);
        regWrite <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'h0;
        @(negedge mclk);
        rv = regRdata;
    endtask
    task automatic wait_mode(input logic [1:0] md);
        for (int i = 0; i < 3000 && activeMode !== md; i++) cyc(1);
        chk(activeMode, md);
    endtask
    // Order {cold, cool, warm, hot}; an out-of-range zone also sets the inner flag.
    function automatic logic [8:0] exp_chg(input logic [3:0] z, input logic en, input logic [5:0] c);
        if (en && (z[3] || z[0])) return {3'h1, c};
        if (en && z[2]) return {3'h6, c};
        if (en && z[1]) return {3'h4, c - pmc_pkg::WARM_CV_DROP};
        return {3'h4, c};
    endfunction
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(8 * 150000);
        n_mismatch++;
        final_report();
    end

    initial begin
        {mclk, regWrite, regRead, regAddr, regWdata, tempCmp, pinReq} = '0;
        {supplyBelowPrewarn, input_current_limit, railAtBattery, railAboveBattery, railBelowBattery} = '0;
        {n_mismatch, compares, t, pu, cr, vu} = '0;
        srst = 1'h1;
        buttonN = 1'h1;
        void'($urandom(32'hBEE1));
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        chk(supply_source_select, 2'h0);
        wr(8'h27, 8'hFF);
        for (int a = 32; a < 40; a++) begin
            rd(8'(a));
            chk(rv, 8'h00);
        end
        for (int s = 0; s < 4; s++) begin
            d = {2'h0, 2'($urandom), 2'h0, 2'(s)};
            wr(8'h20, d);
            cyc(3);
            chk({supply_prewarn_threshold, supply_source_select}, {d[5:4], d[1:0]});
        end
        supplyBelowPrewarn <= 1'h1;
        cyc(4);
        chk(prewarnEvent, 1'h1);
        supplyBelowPrewarn <= 1'h0;
        wr(8'h70, 8'h01);
        cyc(3);
        chk(prewarnEvent, 1'h0);
        cv = 6'h8 + 6'($urandom % 56);
        wr(8'h21, {2'h0, cv});
        for (int e = 1; e >= 0; e--) begin
            wr(8'h20, {5'h0, 1'(e), 2'h0});
            foreach (ZONES[i]) begin
                tempCmp <= ZONES[i];
                cyc(4);
                m = (e == 1 && (ZONES[i][3] || ZONES[i][0])) ? 9'h140 : 9'h1FF;
                chk(chargeCtrl & m, exp_chg(ZONES[i], 1'(e), cv) & m);
            end
        end
        tempCmp <= '0;
        input_current_limit <= 1'h1;
        railAtBattery <= 1'h1;
        cyc(4);
        chk(chargeCtrl.chargeEnable, 1'h0);
        railAtBattery <= 1'h0;
        railAboveBattery <= 1'h1;
        cyc(150 * MSC);
        chk(chargeCtrl.chargeEnable, 1'h0);
        cyc(150 * MSC + 10);
        chk(chargeCtrl.chargeEnable, 1'h1);
        railAboveBattery <= 1'h0;
        railBelowBattery <= 1'h1;
        cyc(4);
        chk(batterySupplement, 1'h1);
        input_current_limit <= 1'h0;
        cyc(5);
        chk(batterySupplement, 1'h0);
        railBelowBattery <= 1'h0;
        for (int i = 0; i < 4; i++) wr(8'(35 + i), {3'h0, 1'(i == 3), RAILS[i]});
        wr(8'h22, 8'h0F);
        pinReq <= 2'h2;
        buttonN <= 1'h0;
        t = 0;
        cyc(DEG + 100);
        chk(pu >= DEG && pu <= DEG + 6, 1'h1);
        rd(8'h71);
        chk(rv[7], 1'h0);
        rd(8'h22);
        chk(rv[3:0], 4'h0);
        buttonN <= 1'h1;
        cyc(DEG + 200);
        rd(8'h71);
        chk(rv[7], 1'h1);
        chk({activeMode, railEnable}, {2'h0, RAILS[0]});
        wr(8'h22, 8'h10);
        wait_mode(2'h1);
        pinReq <= 2'h1;
        cyc(700);
        wr(8'h22, 8'h0E);
        cyc(50);
        chk(activeMode, 2'h1);
        for (int p = 1; p < 4; p++) begin
            pinReq <= 2'(p);
            wait_mode(2'(p));
            cyc(100);
            chk(railEnable, RAILS[p]);
        end
        wr(8'h20, 8'h01);
        buttonN <= 1'h0;
        t = 0;
        cyc(DEG + 100);
        chk(activeMode, 2'h0);
        cyc(4000);
        chk(cr >= pmc_pkg::LONG_UNIT_MS * MSC && cr <= pmc_pkg::LONG_UNIT_MS * MSC + DEG + 40, 1'h1);
        chk(supply_source_select, 2'h0);
        rd(8'h23);
        chk(rv, 8'h00);
        buttonN <= 1'h1;
        chk(vu, 32'h4);
        final_report();
    end
endmodule
